// *** verilog/chuck_pkg.sv ***
package chuck_pkg;

    // ************************************************************
    // register map (word aligned byte offsets)
    // ************************************************************
    localparam logic [7:0] CFG_OFS      = 8'h00;
    localparam logic [7:0] CMD_OFS      = 8'h04;
    localparam logic [7:0] STATUS_OFS   = 8'h08;
    localparam logic [7:0] PULSE_OFS    = 8'h0C;
    localparam logic [7:0] TIMEOUT_OFS  = 8'h10;
    localparam logic [7:0] ALARM_OFS    = 8'h14;

    // ************************************************************
    // configuration field positions
    // ************************************************************
    localparam int CFG_CHUCK_DISABLE    = 0;
    localparam int CFG_INTERLOCK_OFF    = 1;
    localparam int CFG_CONT_CHECK       = 2;
    localparam int CFG_INNER_MODE       = 3;
    localparam int CFG_RESP_CHECK       = 4;
    localparam int CFG_PULSE_MODE       = 5;
    localparam int CFG_PEDAL_DISABLE    = 6;
    localparam logic [6:0] CFG_RESET    = 7'h00;

    // ************************************************************
    // command register bits (write one to issue)
    // ************************************************************
    localparam int CMD_CLAMP            = 0;
    localparam int CMD_RELEASE          = 1;
    localparam int CMD_CANCEL           = 2;

    // ************************************************************
    // alarm register bits (write one to clear)
    // ************************************************************
    localparam int ALM_CLAMP_TIMEOUT    = 0;
    localparam int ALM_RELEASE_TIMEOUT  = 1;
    localparam int ALM_PEDAL_HELD       = 2;
    localparam int ALM_INTERLOCK        = 3;
    localparam int ALM_UNEXPECTED_REL   = 4;
    localparam int ALM_SPINDLE_REFUSED  = 5;

    // ************************************************************
    // timing: default figures in microseconds, cycles at 200 MHz
    // ************************************************************
    localparam int CLK_MHZ              = 200;
    localparam int PULSE_WIDTH_US       = 100;
    localparam int RESP_TIMEOUT_US      = 1000;
    localparam logic [31:0] PULSE_CYCLES   = 32'(PULSE_WIDTH_US * CLK_MHZ);
    localparam logic [31:0] TIMEOUT_CYCLES = 32'(RESP_TIMEOUT_US * CLK_MHZ);

    // ************************************************************
    // sequencer states, gray along idle -> drive -> wait
    // ************************************************************
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_DRIVE = 2'b01,
        ST_WAIT  = 2'b11
    } seq_state_t;

endpackage

// *** verilog/hydraulic_chuck_sequencer.sv ***
// Notes on behaviour
// - manual mode takes clamp, release, cancel; cancel drops the drive.
// - chuck disable bit high removes commands and footswitch handling.
// - interlock-off bit low enables chuck/spindle interlock; high disables it.
// - continuous-check bit enables continuous monitoring of response inputs.
// - inner mode swaps clamp and release output pins, nothing else.
// - response check waits for in-position; shows green normal, yellow abnormal.
// - pulse-mode bit selects level or timed pulse outputs.
// - pedal-disable bit high ignores the footswitch.
// - clamp asserts clamp output; without checking, clamp completes immediately.
// - checked clamp needs clamp sense low, release sense high before timeout.
// - checked release needs release sense low, clamp sense high before timeout.
// - each footswitch press toggles between clamp and release.
// - entering manual or auto with footswitch pressed raises an alarm.
// - reset assumes released; first effective press clamps.
// - interlock: refuse chuck during spindle run; refuse spindle start while released.
// - footswitch ignored during automatic continuous execution.
// - failed or interrupted operation sets uncertain flag, flashing red, blocks start.
// - continuous checking watches for unexpected release while clamped.
// - cancel state sets a cancelled indication beside displayed state.
//
// Implementation choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module hydraulic_chuck_sequencer #(
    parameter logic [31:0] PULSE_CYCLES_DEF   = chuck_pkg::PULSE_CYCLES,
    parameter logic [31:0] TIMEOUT_CYCLES_DEF = chuck_pkg::TIMEOUT_CYCLES,
    parameter int          FLASH_BITS         = 24
) (
    input  wire logic        mclk_in,
    input  wire logic        rst_in,
    input  wire logic        estop_in,
    // classic wishbone slave
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [7:0]  wb_adr_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic [31:0] wb_dat_in,
    output logic      [31:0] wb_dat_out,
    output logic             wb_ack_out,
    // machine context
    input  wire logic        manual_mode_in,
    input  wire logic        auto_mode_in,
    input  wire logic        auto_cont_in,
    input  wire logic        spindle_run_in,
    input  wire logic        spindle_start_req_in,
    input  wire logic        program_start_req_in,
    input  wire logic        footswitch_in,
    input  wire logic        clamp_sense_in,
    input  wire logic        release_sense_in,
    // valves and indications
    output logic             clamp_output_out,
    output logic             release_output_out,
    output logic             spindle_start_ok_out,
    output logic             program_start_ok_out,
    output logic             resp_green_out,
    output logic             resp_yellow_out,
    output logic             red_flash_out,
    output logic             cancelled_out,
    output logic             clamped_state_out,
    output logic             busy_out
);

    // ************************************************************
    // state record
    // ************************************************************
    typedef struct packed {
        logic [31:0]            rdata;
        logic                   ack;
        logic [6:0]             cfg;
        logic [31:0]            pulse_cycles;
        logic [31:0]            timeout_cycles;
        logic [5:0]             alarm;
        chuck_pkg::seq_state_t  st;
        logic                   target_clamp;   // direction of last operation, high for clamp
        logic                   clamped;        // logical chuck state
        logic                   cancelled;
        logic                   uncertain;
        logic                   resp_bad;
        logic [31:0]            pulse_cnt;
        logic [31:0]            tmo_cnt;
        logic                   drive;          // drive currently asserted
        logic                   pedal_prev;
        logic                   mode_prev;
        logic [FLASH_BITS-1:0]  flash;
        logic                   clamp_o;
        logic                   release_o;
        logic                   spin_ok;
        logic                   prog_ok;
    } state_t;

    state_t s;
    state_t next_s;

    logic bus_req;
    logic wr_cmd;
    logic [31:0] wmask;
    logic in_clamp_pos;
    logic in_release_pos;
    logic op_clamp;
    logic op_release;
    logic op_cancel;
    logic pedal_edge;
    logic mode_on;
    logic chuck_on;
    logic ilock_on;
    logic in_pos;
    logic [6:0] c;

    // ************************************************************
    // decode helpers
    // ************************************************************
    always_comb begin
        c        = s.cfg;
        chuck_on = !c[chuck_pkg::CFG_CHUCK_DISABLE];
        ilock_on = !c[chuck_pkg::CFG_INTERLOCK_OFF];
        bus_req  = wb_cyc_in && wb_stb_in && !s.ack;
        wmask    = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}},
                    {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
        wr_cmd   = bus_req && wb_we_in && wb_adr_in == chuck_pkg::CMD_OFS && wb_sel_in[0];
        // sense inputs are active low
        in_clamp_pos   = !clamp_sense_in && release_sense_in;
        in_release_pos = !release_sense_in && clamp_sense_in;
        mode_on    = manual_mode_in || auto_mode_in;
        // edge detect on a press; inputs taken as already synchronous
        pedal_edge = footswitch_in && !s.pedal_prev;
        // footswitch only counts when enabled and not in continuous run
        op_clamp   = 1'b0;
        op_release = 1'b0;
        op_cancel  = 1'b0;
        if (chuck_on && manual_mode_in && wr_cmd) begin
            op_clamp   = wb_dat_in[chuck_pkg::CMD_CLAMP];
            op_release = wb_dat_in[chuck_pkg::CMD_RELEASE] && !wb_dat_in[chuck_pkg::CMD_CLAMP];
            op_cancel  = wb_dat_in[chuck_pkg::CMD_CANCEL];
        end
        if (chuck_on && pedal_edge && mode_on && !auto_cont_in
            && !c[chuck_pkg::CFG_PEDAL_DISABLE]) begin
            // reset leaves released, so first press clamps
            op_clamp   = !s.clamped;
            op_release = s.clamped;
        end
        in_pos = s.target_clamp ? in_clamp_pos : in_release_pos;
    end

    // ************************************************************
    // next-state logic
    // ************************************************************
    always_comb begin
        next_s            = s;
        next_s.ack        = bus_req;
        next_s.pedal_prev = footswitch_in;
        next_s.mode_prev  = mode_on;
        next_s.flash      = s.flash + 1'b1;

        // register writes with byte lanes
        if (bus_req && wb_we_in) begin
            if (wb_adr_in == chuck_pkg::CFG_OFS) begin
                if (wb_sel_in[0]) next_s.cfg = wb_dat_in[6:0];
            end else if (wb_adr_in == chuck_pkg::PULSE_OFS) begin
                next_s.pulse_cycles = (s.pulse_cycles & ~wmask) | (wb_dat_in & wmask);
            end else if (wb_adr_in == chuck_pkg::TIMEOUT_OFS) begin
                next_s.timeout_cycles = (s.timeout_cycles & ~wmask) | (wb_dat_in & wmask);
            end else if (wb_adr_in == chuck_pkg::ALARM_OFS) begin
                if (wb_sel_in[0]) next_s.alarm = s.alarm & ~wb_dat_in[5:0];
            end
        end

        // abnormality if a mode is entered with pedal held
        if (mode_on && !s.mode_prev && footswitch_in && chuck_on)
            next_s.alarm[chuck_pkg::ALM_PEDAL_HELD] = 1'b1;

        // spindle start refused while released under interlock
        next_s.spin_ok = !(chuck_on && ilock_on && !s.clamped);
        if (spindle_start_req_in && chuck_on && ilock_on && !s.clamped)
            next_s.alarm[chuck_pkg::ALM_SPINDLE_REFUSED] = 1'b1;
        next_s.prog_ok = !s.uncertain;

        // sequencer
        if (estop_in) begin
            // interrupted operation leaves position unknown
            if (s.st != chuck_pkg::ST_IDLE) next_s.uncertain = 1'b1;
            next_s.st      = chuck_pkg::ST_IDLE;
            next_s.clamped = 1'b0;
            next_s.drive   = 1'b0;
            next_s.cancelled = 1'b0;
        end else if (op_cancel) begin
            next_s.drive     = 1'b0;
            next_s.cancelled = 1'b1;
            if (s.st != chuck_pkg::ST_IDLE) next_s.uncertain = 1'b1;
            next_s.st        = chuck_pkg::ST_IDLE;
        end else if ((op_clamp || op_release) && ilock_on && spindle_run_in) begin
            next_s.alarm[chuck_pkg::ALM_INTERLOCK] = 1'b1;
        end else if (op_clamp || op_release) begin
            next_s.target_clamp = op_clamp;
            next_s.clamped      = op_clamp;   // logical state kept in pulse mode
            next_s.drive        = 1'b1;
            next_s.cancelled    = 1'b0;
            next_s.pulse_cnt    = s.pulse_cycles;
            next_s.tmo_cnt      = s.timeout_cycles;
            next_s.st           = c[chuck_pkg::CFG_RESP_CHECK] ? chuck_pkg::ST_WAIT
                                                               : chuck_pkg::ST_DRIVE;
            if (!c[chuck_pkg::CFG_RESP_CHECK]) next_s.uncertain = 1'b0;
        end else begin
            // pulse timing, independent of the wait
            if (s.drive && c[chuck_pkg::CFG_PULSE_MODE]) begin
                if (s.pulse_cnt <= 32'h0000_0001) next_s.drive = 1'b0;
                else next_s.pulse_cnt = s.pulse_cnt - 32'h0000_0001;
            end
            case (s.st)
                chuck_pkg::ST_IDLE: begin
                end
                chuck_pkg::ST_DRIVE: begin
                    next_s.st = chuck_pkg::ST_IDLE;
                end
                chuck_pkg::ST_WAIT: begin
                    if (in_pos) begin
                        next_s.st        = chuck_pkg::ST_IDLE;
                        next_s.uncertain = 1'b0;
                        next_s.resp_bad  = 1'b0;
                        next_s.tmo_cnt   = 32'h0000_0000;
                    end else if (s.tmo_cnt <= 32'h0000_0001) begin
                        next_s.st        = chuck_pkg::ST_IDLE;
                        next_s.uncertain = 1'b1;
                        next_s.resp_bad  = 1'b1;
                        if (s.target_clamp)
                            next_s.alarm[chuck_pkg::ALM_CLAMP_TIMEOUT] = 1'b1;
                        else
                            next_s.alarm[chuck_pkg::ALM_RELEASE_TIMEOUT] = 1'b1;
                    end else begin
                        next_s.tmo_cnt = s.tmo_cnt - 32'h0000_0001;
                    end
                end
                default: next_s.st = chuck_pkg::ST_IDLE;
            endcase
        end

        // continuous monitoring for an unexpected release while clamped
        if (chuck_on && c[chuck_pkg::CFG_CONT_CHECK] && s.st == chuck_pkg::ST_IDLE
            && s.clamped && !s.cancelled && !in_clamp_pos) begin
            next_s.alarm[chuck_pkg::ALM_UNEXPECTED_REL] = 1'b1;
            next_s.resp_bad = 1'b1;
        end

        // function absent: outputs quiet
        if (!chuck_on) next_s.drive = 1'b0;

        // pin mapping; inner mode swaps the pins, one pin at a time
        next_s.clamp_o   = next_s.drive && (next_s.target_clamp ^ c[chuck_pkg::CFG_INNER_MODE]);
        next_s.release_o = next_s.drive && !(next_s.target_clamp ^ c[chuck_pkg::CFG_INNER_MODE]);

        // read mux
        next_s.rdata = 32'h0000_0000;
        if (bus_req && !wb_we_in) begin
            if (wb_adr_in == chuck_pkg::CFG_OFS) begin
                next_s.rdata = {25'h0, s.cfg};
            end else if (wb_adr_in == chuck_pkg::STATUS_OFS) begin
                next_s.rdata = {24'h0, s.resp_bad, s.uncertain, s.cancelled, s.clamped,
                                s.target_clamp, s.drive, s.st};
            end else if (wb_adr_in == chuck_pkg::PULSE_OFS) begin
                next_s.rdata = s.pulse_cycles;
            end else if (wb_adr_in == chuck_pkg::TIMEOUT_OFS) begin
                next_s.rdata = s.timeout_cycles;
            end else if (wb_adr_in == chuck_pkg::ALARM_OFS) begin
                next_s.rdata = {26'h0, s.alarm};
            end
        end
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            s <= '{cfg: chuck_pkg::CFG_RESET, pulse_cycles: PULSE_CYCLES_DEF,
                   timeout_cycles: TIMEOUT_CYCLES_DEF, st: chuck_pkg::ST_IDLE,
                   spin_ok: 1'b1, prog_ok: 1'b1, default: '0};
        end else begin
            s <= next_s;
        end
    end

    // ************************************************************
    // outputs from flip-flops; lights, red flash and busy gated from them
    // ************************************************************
    assign wb_dat_out           = s.rdata;
    assign wb_ack_out           = s.ack;
    assign clamp_output_out     = s.clamp_o;
    assign release_output_out   = s.release_o;
    assign spindle_start_ok_out = s.spin_ok;
    assign program_start_ok_out = s.prog_ok;
    assign resp_green_out       = s.cfg[chuck_pkg::CFG_RESP_CHECK] && !s.resp_bad;
    assign resp_yellow_out      = s.cfg[chuck_pkg::CFG_RESP_CHECK] && s.resp_bad;
    assign red_flash_out        = s.uncertain && s.flash[FLASH_BITS-1];
    assign cancelled_out        = s.cancelled;
    assign clamped_state_out    = s.clamped;
    assign busy_out             = s.st != chuck_pkg::ST_IDLE;

endmodule

`default_nettype wire

// *** bench/chuck_chk.sv ***
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// checker on valve drives, bus answer and interlock flags
// ************************************************************
module chuck_chk (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic estop_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_ack_out,
    input wire logic clamp_output_out,
    input wire logic release_output_out,
    input wire logic spindle_start_ok_out,
    input wire logic program_start_ok_out,
    input wire logic resp_green_out,
    input wire logic resp_yellow_out,
    input wire logic red_flash_out,
    input wire logic cancelled_out,
    input wire logic clamped_state_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    // outputs exclusive
    property p_no_both; !(clamp_output_out && release_output_out); endproperty
    a_no_both: assert property (p_no_both)
        else $error("clamp and release driven together");
    property p_ack_next; wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out; endproperty
    a_ack_next: assert property (p_ack_next)
        else $error("bus request not answered next cycle");
    property p_ack_one; wb_ack_out |=> !wb_ack_out; endproperty
    a_ack_one: assert property (p_ack_one)
        else $error("bus answer longer than one cycle");
    // flag is registered: one cycle of lag
    property p_spin;
        !spindle_start_ok_out |-> !clamped_state_out || !$past(clamped_state_out);
    endproperty
    a_spin: assert property (p_spin)
        else $error("spindle start refused while clamped");
    property p_red; red_flash_out |-> ##[0:1] !program_start_ok_out; endproperty
    a_red: assert property (p_red)
        else $error("program start allowed while uncertain");
    property p_estop; estop_in |-> ##[1:2] !clamped_state_out; endproperty
    a_estop: assert property (p_estop)
        else $error("stop did not force released state");
    property p_cancel; $rose(cancelled_out) |-> ##[0:1] !clamp_output_out && !release_output_out;
    endproperty
    a_cancel: assert property (p_cancel)
        else $error("cancel left a valve driven");
    property p_lights; !(resp_green_out && resp_yellow_out); endproperty
    a_lights: assert property (p_lights)
        else $error("green and yellow lit together");

    c_red: cover property (red_flash_out);
    c_cancel: cover property ($rose(cancelled_out));
    c_spin: cover property (!spindle_start_ok_out && !clamped_state_out);
endmodule

bind hydraulic_chuck_sequencer chuck_chk chk_u (.*);
`default_nettype wire

// *** bench/chuck_valves.sv ***
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// jaws, valves and in-position switches
// ************************************************************
module chuck_valves (
    input  wire logic mclk_in,
    input  wire logic clamp_drive_in,
    input  wire logic release_drive_in,
    input  wire logic inner_in,
    input  wire logic stuck_in,
    input  wire logic drop_in,
    output logic      clamp_sense_out,
    output logic      release_sense_out
);
    logic       pos = 1'b0;
    logic       moving = 1'b0;
    logic [1:0] travel = 2'h0;
    logic       want;

    // inner chuck: the release valve closes the jaws
    assign want = inner_in ? release_drive_in : clamp_drive_in;
    // four-cycle stroke; stuck jaw stays put
    always @(posedge mclk_in) begin
        moving <= 1'b0;
        travel <= 2'h0;
        if (drop_in) begin
            pos <= 1'b0;
        end else if (!stuck_in && (clamp_drive_in || release_drive_in) && want != pos) begin
            moving <= 1'b1;
            travel <= travel + 2'h1;
            if (travel == 2'h3) begin
                pos <= want;
            end
        end
    end
    // both switches open mid-stroke; low marks the side reached
    assign clamp_sense_out = moving || !pos;
    assign release_sense_out = moving || pos;
endmodule
`default_nettype wire

// *** bench/tb_hydraulic_chuck_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_hydraulic_chuck_sequencer;
    // ************************************************************
    // settings, stimulus and observed signals
    // ************************************************************
    localparam logic [31:0] PW = 32'h6, TMO = 32'h14;
    localparam logic [31:0] DIS = 32'h01, IOFF = 32'h02, CONT = 32'h04, INN = 32'h08;
    localparam logic [31:0] RESP = 32'h10, PULS = 32'h20, PED = 32'h40;
    typedef struct packed {
        logic [31:0] cfg;
        logic [2:0]  cmd;
        logic [3:0]  exp;
    } row_t;
    logic mclk_in = 1'b0, rst_in = 1'b1, estop_in = 1'b0, wb_cyc_in = 1'b0, wb_stb_in = 1'b0;
    logic wb_we_in = 1'b0, manual_mode_in = 1'b1, auto_mode_in = 1'b0, auto_cont_in = 1'b0;
    logic spindle_run_in = 1'b0, spindle_start_req_in = 1'b0, program_start_req_in = 1'b0;
    logic footswitch_in = 1'b0, inn = 1'b0, stuck = 1'b0, drop = 1'b0;
    logic [7:0]  wb_adr_in = 8'h00;
    logic [3:0]  wb_sel_in = 4'hF;
    logic [31:0] wb_dat_in = 32'h0, wb_dat_out, q;
    logic wb_ack_out, clamp_output_out, release_output_out, spindle_start_ok_out, busy_out;
    logic program_start_ok_out, resp_green_out, resp_yellow_out, red_flash_out, cancelled_out;
    logic clamped_state_out, clamp_sense_in, release_sense_in;
    logic [3:0]  outs;
    int          miscompares = 0, checks_done = 0, hi_cnt = 0, base;
    row_t rows [7] = '{
        '{IOFF, 3'h1, 4'hA}, '{IOFF, 3'h2, 4'h4}, '{IOFF | INN, 3'h1, 4'h6},
        '{IOFF | INN, 3'h2, 4'h8}, '{IOFF | INN, 3'h4, 4'h1}, '{IOFF, 3'h1, 4'hA},
        '{IOFF, 3'h4, 4'h3}
    };

    hydraulic_chuck_sequencer #(.PULSE_CYCLES_DEF(PW), .TIMEOUT_CYCLES_DEF(TMO), .FLASH_BITS(3))
    dut_u (.*);
    chuck_valves valves_u (
        .mclk_in, .clamp_drive_in(clamp_output_out), .release_drive_in(release_output_out),
        .inner_in(inn), .stuck_in(stuck), .drop_in(drop),
        .clamp_sense_out(clamp_sense_in), .release_sense_out(release_sense_in)
    );
    assign outs = {clamp_output_out, release_output_out, clamped_state_out, cancelled_out};

    // clock; valve-on tally
    always #2.5 mclk_in = ~mclk_in;
    always @(posedge mclk_in) hi_cnt <= hi_cnt + int'(clamp_output_out | release_output_out);

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge mclk_in);
        @(negedge mclk_in);
    endtask
    // one classic cycle: held until ack is seen at a rising edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k = 0;
        @(posedge mclk_in);
        {wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_dat_in} <= {2'b11, w, a, d};
        do begin
            @(posedge mclk_in);
            k++;
        end while (wb_ack_out !== 1'b1 && k < 50);
        chk(k < 50, 32'h1);
        q = wb_dat_out;
        {wb_cyc_in, wb_stb_in} <= 2'b00;
    endtask
    task automatic rdq(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    task automatic alm(input int b);
        wb(1'b0, chuck_pkg::ALARM_OFS, 32'h0);
        chk(q[b], 32'h1);
    endtask
    task automatic cfg(input logic [31:0] c);
        wb(1'b1, chuck_pkg::CFG_OFS, c);
        inn <= c[chuck_pkg::CFG_INNER_MODE];
    endtask
    task automatic cmd(input logic [31:0] c);
        wb(1'b1, chuck_pkg::CMD_OFS, c);
    endtask
    task automatic idle;
        int k = 0;
        @(negedge mclk_in);
        while (busy_out !== 1'b0 && k < 200) begin
            @(negedge mclk_in);
            k++;
        end
        chk(k < 200, 32'h1);
    endtask
    task automatic press;
        @(posedge mclk_in);
        footswitch_in <= 1'b1;
        tick(3);
        @(posedge mclk_in);
        footswitch_in <= 1'b0;
        tick(3);
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ************************************************************
    // sequence and watchdog
    // ************************************************************
    initial begin
        #100000;
        miscompares++;
        print_verdict();
    end
    initial begin
        repeat (8) @(posedge mclk_in);
        rst_in <= 1'b0;
        tick(1);
        chk(outs, 4'h0);
        chk(program_start_ok_out, 32'h1);
        rdq(chuck_pkg::CFG_OFS, 32'h0);
        rdq(chuck_pkg::PULSE_OFS, PW);
        rdq(chuck_pkg::TIMEOUT_OFS, TMO);
        rdq(8'h3C, 32'h0);
        done("reset");
        foreach (rows[i]) begin
            cfg(rows[i].cfg);
            cmd(32'(rows[i].cmd));
            tick(2);
            chk(outs, rows[i].exp);
        end
        done("commands");
        // pulse: valve drops, state stays
        cfg(PULS | IOFF);
        base = hi_cnt;
        cmd(32'h2);
        tick(12);
        chk(hi_cnt - base, PW);
        chk(outs, 4'h0);
        done("pulse");
        // checked clamp, stuck release times out
        cfg(RESP | IOFF);
        wb(1'b1, chuck_pkg::ALARM_OFS, 32'h3F);
        cmd(32'h1);
        idle();
        rdq(chuck_pkg::ALARM_OFS, 32'h0);
        chk(resp_green_out, 32'h1);
        @(posedge mclk_in);
        stuck <= 1'b1;
        cmd(32'h2);
        idle();
        alm(chuck_pkg::ALM_RELEASE_TIMEOUT);
        chk(resp_yellow_out, 32'h1);
        tick(10);
        chk(program_start_ok_out, 32'h0);
        wb(1'b1, chuck_pkg::ALARM_OFS, 32'h3F);
        stuck <= 1'b0;
        cmd(32'h2);
        idle();
        tick(2);
        chk(program_start_ok_out, 32'h1);
        done("response");
        cfg(32'h0);
        tick(2);
        chk(spindle_start_ok_out, 32'h0);
        @(posedge mclk_in);
        spindle_run_in <= 1'b1;
        cmd(32'h1);
        tick(2);
        chk(clamped_state_out, 32'h0);
        alm(chuck_pkg::ALM_INTERLOCK);
        @(posedge mclk_in);
        spindle_run_in <= 1'b0;
        spindle_start_req_in <= 1'b1;
        tick(2);
        alm(chuck_pkg::ALM_SPINDLE_REFUSED);
        spindle_start_req_in <= 1'b0;
        cfg(DIS | IOFF);
        cmd(32'h1);
        press();
        chk(clamped_state_out, 32'h0);
        done("interlock");
        cfg(IOFF);
        press();
        chk(clamped_state_out, 32'h1);
        @(posedge mclk_in);
        estop_in <= 1'b1;
        tick(2);
        @(posedge mclk_in);
        estop_in <= 1'b0;
        tick(2);
        chk(clamped_state_out, 32'h0);
        press();
        chk(clamped_state_out, 32'h1);
        press();
        chk(clamped_state_out, 32'h0);
        cfg(PED | IOFF);
        press();
        chk(clamped_state_out, 32'h0);
        cfg(IOFF);
        manual_mode_in <= 1'b0;
        auto_mode_in <= 1'b1;
        auto_cont_in <= 1'b1;
        press();
        chk(clamped_state_out, 32'h0);
        @(posedge mclk_in);
        auto_mode_in <= 1'b0;
        auto_cont_in <= 1'b0;
        footswitch_in <= 1'b1;
        tick(2);
        @(posedge mclk_in);
        manual_mode_in <= 1'b1;
        tick(3);
        alm(chuck_pkg::ALM_PEDAL_HELD);
        footswitch_in <= 1'b0;
        done("footswitch");
        cfg(CONT | IOFF);
        cmd(32'h1);
        tick(8);
        wb(1'b1, chuck_pkg::ALARM_OFS, 32'h3F);
        drop <= 1'b1;
        tick(4);
        alm(chuck_pkg::ALM_UNEXPECTED_REL);
        drop <= 1'b0;
        done("monitor");
        print_verdict();
    end
endmodule
`default_nettype wire
